//--- bench/audio_codec_model.sv
// Converter model on the far side of the serial audio lines
`timescale 1ns/10ps
`default_nettype none
module audio_codec_model (
  // Clock and setup
  input  wire logic        clk,
  input  wire logic        fmt,
  input  wire logic        arm,
  // Serial lines
  input  wire logic        bclk,
  input  wire logic        ws,
  input  wire logic [7:0]  dout,
  output var  logic [7:0]  din,
  output wire logic [1:0]  xbclk,
  output wire logic [1:0]  xws,
  // Sample values
  input  wire logic [23:0] send [16],
  output var  logic [23:0] seen [16],
  output var  logic        pad_ok
);
  logic [31:0] sr [8];
  logic [1:0]  bd = 2'b00;
  logic [1:0]  wd = 2'b00;
  logic        bq = 1'b0;
  logic        wq = 1'b0;
  logic        rq;
  int          pos = 0;
  int          k;
  // Pair 0 trails the device clocks at the same rate; pair 1 stands still
  assign xbclk = {1'b0, bd[1]};
  assign xws   = {1'b0, wd[1]};
  initial din = 8'h00;
  initial pad_ok = 1'b1;
  always @(posedge clk) begin
    bd <= {bd[0], bclk};
    wd <= {wd[0], ws};
    bq <= bclk;
    if (bclk && !bq) begin
      rq <= ws;
      for (int l = 0; l < 8; l++) begin
        sr[l] <= {sr[l][30:0], dout[l]};
        if (arm && ws != rq) begin
          seen[2*l+rq] <= fmt ? sr[l][31:8] : sr[l][30:7];
          if ((fmt ? sr[l][7:0] : {1'b0, sr[l][6:0]}) != 8'h00)
            pad_ok <= 1'b0;
        end
      end
    end
    if (!bclk && bq) begin
      k = (ws != wq) ? 0 : pos + 1;
      pos <= k;
      wq <= ws;
      k = k - (fmt ? 0 : 1);
      for (int l = 0; l < 8; l++)
        din[l] <= (k >= 0 && k < 24) ? send[2*l+ws][23-k] : ~din[l];
    end
  end
endmodule
`default_nettype wire

//--- bench/audio_port_checker.sv
// Pin-level assertions for the audio port
`timescale 1ns/10ps
`default_nettype none
module audio_port_checker (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Audio pins
  input wire logic        BIT_CLOCK_OUT,
  input wire logic        WORD_SELECT_OUT,
  input wire logic [7:0]  AUDIO_DATA_OUT_LINES
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [5:0] rises;
  logic       primed;
  // Bit clock rises since the last word select flip
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rises  <= 6'h00;
      primed <= 1'b0;
    end else if ($changed(WORD_SELECT_OUT)) begin
      rises  <= 6'h00;
      primed <= 1'b1;
    end else if ($rose(BIT_CLOCK_OUT)) begin
      rises <= rises + 6'h01;
    end
  end
  sequence s_wait; !PREADY ##[1:2] PREADY; endsequence
  sequence s_fall; $fell(BIT_CLOCK_OUT); endsequence
  property p_ready_wait; $rose(PENABLE) && PSEL |-> s_wait; endproperty
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  property p_ready_cause; PREADY |-> PSEL && PENABLE; endproperty
  property p_err; PSLVERR && !PWRITE |-> PREADY && PRDATA == 0; endproperty
  property p_ws_fall; $changed(WORD_SELECT_OUT) |-> s_fall; endproperty
  property p_data_fall; $changed(AUDIO_DATA_OUT_LINES) |-> s_fall; endproperty
  property p_slot; $changed(WORD_SELECT_OUT) && primed |-> rises == 6'h20;
  endproperty
  property p_ws_hold; $rose(BIT_CLOCK_OUT) |-> $stable(WORD_SELECT_OUT);
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no ready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready");
  a_ready_cause: assert property (p_ready_cause) else $error("stray");
  a_err: assert property (p_err) else $error("error reply");
  a_ws_fall: assert property (p_ws_fall) else $error("ws moved");
  a_data_fall: assert property (p_data_fall) else $error("data moved");
  a_slot: assert property (p_slot) else $error("slot length");
  a_ws_hold: assert property (p_ws_hold) else $error("ws near rise");
endmodule
bind audio_port audio_port_checker u_audio_port_checker (
  .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BIT_CLOCK_OUT(BIT_CLOCK_OUT), .WORD_SELECT_OUT(WORD_SELECT_OUT),
  .AUDIO_DATA_OUT_LINES(AUDIO_DATA_OUT_LINES));
`default_nettype wire

//--- bench/multichannel_digital_audio_port_test.sv
// Self-checking bench for the multichannel audio port
`timescale 1ns/10ps
`default_nettype none
module multichannel_digital_audio_port_test;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, BCLK, WS, MCLK, fmt = 1'b0, arm = 1'b0, pad_ok;
  logic [7:0]  DOUT, DIN;
  logic [1:0]  XB, XW;
  logic [23:0] tx [16], rx [16], seen [16];
  logic [32:0] exp_q [$];
  int          mismatches = 0, tests_run = 0, mclk_n = 0;
  always #12.5 CLK_SYS = ~CLK_SYS;
  always @(posedge MCLK) mclk_n++;
  audio_port u_audio_port (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BIT_CLOCK_OUT(BCLK), .WORD_SELECT_OUT(WS), .MASTER_CLOCK_OUT(MCLK),
    .AUDIO_DATA_OUT_LINES(DOUT), .AUDIO_DATA_IN_LINES(DIN),
    .EXT_BIT_CLOCK_IN(XB), .EXT_WORD_SELECT_IN(XW));
  audio_codec_model u_audio_codec_model (.clk(CLK_SYS), .fmt(fmt),
    .arm(arm), .bclk(BCLK), .ws(WS), .dout(DOUT), .din(DIN), .xbclk(XB),
    .xws(XW), .send(rx), .seen(seen), .pad_ok(pad_ok));
  task automatic check(input string n, input logic [32:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge WS);
    @(posedge CLK_SYS);
  endtask
  function automatic logic [31:0] ctl(input logic f, input logic [2:0] r);
    return {16'h0000, 8'h0C, 1'b0, r, 2'b00, f, 1'b1};
  endfunction
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Read replies are matched against the oldest noted expectation
  always @(posedge CLK_SYS) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
      check("read", {PSLVERR, PRDATA}, exp_q.pop_front());
  end
  initial begin
    int ratio [6] = '{128, 192, 256, 384, 512, 768};
    int base;
    logic [23:0] nw;
    logic [23:0] ex [4];
    void'($urandom(17241));
    repeat (6) @(posedge CLK_SYS);
    for (int f = 0; f < 2; f++) begin
      RST <= 1'b0;
      @(posedge CLK_SYS);
      fmt <= f[0];
      for (int c = 0; c < 16; c++) begin
        tx[c] = 24'($urandom);
        rx[c] <= 24'($urandom);
        apb(1'b1, 8'h40 + 8'(4 * c), {8'h00, tx[c]});
      end
      apb(1'b1, 8'h00, ctl(f[0], 3'h2));
      rd(8'h00, {1'b0, ctl(f[0], 3'h2)});
      rd(8'h0C, 33'h1_0000_0000);
      frames(1);
      arm <= 1'b1;
      frames(2);
      for (int c = 0; c < 16; c++) begin
        check("tx", {9'h000, seen[c]}, {9'h000, tx[c]});
        rd(8'h80 + 8'(4 * c), {9'h000, rx[c]});
      end
      check("pad", {32'h0000_0000, pad_ok}, 33'h0_0000_0001);
      arm <= 1'b0;
      RST <= 1'b1;
      @(posedge CLK_SYS);
    end
    RST <= 1'b0;
    fmt <= 1'b0;
    @(posedge CLK_SYS);
    for (int r = 0; r < 6; r++) begin
      apb(1'b1, 8'h00, ctl(1'b0, 3'(r)));
      frames(1);
      base = mclk_n;
      frames(1);
      base = mclk_n - base;
      check("mclk", 33'(base >= ratio[r] - 2 && base <= ratio[r] + 2),
            33'h0_0000_0001);
    end
    apb(1'b1, 8'h04, 32'h0000_000E);
    rd(8'h04, 33'h0_0000_000E);
    for (int c = 0; c < 4; c++) begin
      nw = 24'($urandom);
      ex[c] = (c < 2) ? nw : rx[c];
      rx[c] <= nw;
    end
    frames(3);
    for (int c = 0; c < 4; c++)
      rd(8'h80 + 8'(4 * c), {9'h000, ex[c]});
    wrap_up();
  end
  initial begin
    #1_750_000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire

//--- design/audio_port.sv
// Multichannel serial audio port with APB register access
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Sixteen channels each way, two per line
// - Shared bit clock and word select by default
// - Each input line may use external pair
// - I2S or left-justified, up to 24 bits
// - Bit clock is 64 times word select
// - Master clock 128 to 768 times Fs
// - Supports 48, 96, 192 kHz frame rates
// - Output data change on bit clock fall
// - Inputs sampled on bit clock rise
// - Word select changes away from rise
// - Format and ratio set by firmware
module audio_port (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Audio clocks out
  output var  logic        BIT_CLOCK_OUT,
  output var  logic        WORD_SELECT_OUT,
  output var  logic        MASTER_CLOCK_OUT,
  // Audio data
  output var  logic [7:0]  AUDIO_DATA_OUT_LINES,
  input  wire logic [7:0]  AUDIO_DATA_IN_LINES,
  // External clock pairs for slave inputs
  input  wire logic [1:0]  EXT_BIT_CLOCK_IN,
  input  wire logic [1:0]  EXT_WORD_SELECT_IN
);
  logic [31:0] control;
  logic [15:0] slave_sel;
  logic [7:0]  half_cnt;
  logic [5:0]  bit_cnt;
  logic [23:0] tx_shift [0:7];
  logic [23:0] rx_shift [0:7];
  logic [23:0] rx_hold  [0:15];
  logic [5:0]  rx_bit   [0:7];
  logic        rx_ws_q  [0:7];
  logic [2:0]  load_idx;
  logic        fetch_q;
  logic [2:0]  fetch_idx;
  logic [15:0] frame_count;
  logic        apb_access;
  logic        apb_wr;
  logic        apb_rd;

  // Register decode
  wire         enable     = control[audio_port_pkg::CTRL_ENABLE_BIT];
  wire         fmt_left   = control[audio_port_pkg::CTRL_FORMAT_BIT];
  wire  [2:0]  ratio_sel  = control[audio_port_pkg::CTRL_RATIO_MSB:
                                    audio_port_pkg::CTRL_RATIO_LSB];
  wire  [7:0]  half_div   = control[audio_port_pkg::CTRL_DIV_MSB:
                                    audio_port_pkg::CTRL_DIV_LSB];
  wire  [7:0]  half_limit = (half_div < audio_port_pkg::MIN_HALF_DIV) ?
                            audio_port_pkg::MIN_HALF_DIV : half_div;
  wire         sel_ctrl   = PADDR == audio_port_pkg::ADDR_CONTROL;
  wire         sel_slave  = PADDR == audio_port_pkg::ADDR_SLAVE_SEL;
  wire         sel_status = PADDR == audio_port_pkg::ADDR_STATUS;
  wire         sel_tx     = PADDR[7:6] == audio_port_pkg::ADDR_TX_BASE[7:6]
                            && PADDR[1:0] == 2'b00;
  wire         sel_rx     = PADDR[7:6] == audio_port_pkg::ADDR_RX_BASE[7:6]
                            && PADDR[1:0] == 2'b00;
  wire  [3:0]  chan_idx   = PADDR[5:2];
  wire         mapped     = sel_ctrl | sel_slave | sel_status | sel_tx |
                            sel_rx;

  // Master bit clock timing (one enable pulse per half period)
  wire         half_tick  = enable && (half_cnt == half_limit - 8'h01);
  wire         m_fall     = half_tick && BIT_CLOCK_OUT;
  wire         m_rise     = half_tick && !BIT_CLOCK_OUT;
  wire  [5:0]  next_bit   = bit_cnt + 6'h01;
  // Word select toggles on fall: away from the sampling rise.
  wire         next_ws    = next_bit[5];
  // Slot position of the bit leaving at this fall.
  wire  [5:0]  tx_pos     = fmt_left ? next_bit : next_bit - 6'h01;
  wire  [4:0]  slot_pos   = tx_pos[4:0];
  // Pad bits 25 to 31 leave time to fetch every line's next sample
  wire         fetch_win  = enable && slot_pos > 5'h18;
  wire         fetch_half = !tx_pos[5];

  // Master clock: toggles per half period scaled by ratio.
  logic [6:0]  mclk_div;
  always_comb begin
    unique case (audio_port_pkg::ratio_type'(ratio_sel))
      audio_port_pkg::RATIO_128: mclk_div = 7'h10;
      audio_port_pkg::RATIO_192: mclk_div = 7'h18;
      audio_port_pkg::RATIO_256: mclk_div = 7'h20;
      audio_port_pkg::RATIO_384: mclk_div = 7'h30;
      audio_port_pkg::RATIO_512: mclk_div = 7'h40;
      audio_port_pkg::RATIO_768: mclk_div = 7'h60;
      default:                   mclk_div = 7'h20;
    endcase
  end
  // Accumulator: master clock half period is 8 * half_limit / mclk_div
  // system clocks (ratio / 8 per step), realigned at every bit clock fall
  logic [10:0] mclk_acc;
  wire  [10:0] mclk_step = {4'h0, mclk_div};
  wire  [10:0] mclk_lim  = {half_limit, 3'b000};

  // Slave clock recovery per external pair.
  logic [1:0] x_rise;
  logic [1:0] x_fall;
  logic [1:0] x_ws;
  genvar g;
  generate
    for (g = 0; g < audio_port_pkg::CLOCK_SRCS; g++) begin : g_ext
      audio_slave_sync u_sync (
        .clk     (CLK_SYS),
        .rst     (RST),
        .bclk_in (EXT_BIT_CLOCK_IN[g]),
        .ws_in   (EXT_WORD_SELECT_IN[g]),
        .rise    (x_rise[g]),
        .fall    (),
        .ws      (x_ws[g])
      );
    end
  endgenerate

  // Transmit sample memory: one word per channel.
  logic [23:0] mem_rd;
  wire         mem_wr = apb_wr && sel_tx;
  audio_sample_mem u_tx_mem (
    .clk     (CLK_SYS),
    .wr_en   (mem_wr),
    .wr_addr (chan_idx),
    .wr_data (PWDATA[23:0]),
    .rd_addr ({load_idx, fetch_half}),
    .rd_data (mem_rd)
  );

  // APB: one wait state gives registered read data
  assign apb_wr = apb_access && PWRITE && PREADY;
  assign apb_rd = PSEL && PENABLE && !PWRITE && !PREADY;
  assign apb_access = PSEL && PENABLE;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= apb_access && !PREADY;
      PSLVERR <= apb_access && !PREADY && !mapped;
      if (apb_rd) begin
        PRDATA <= sel_ctrl   ? control :
                  sel_slave  ? {16'h0000, slave_sel} :
                  sel_status ? {frame_count, 15'h0000, WORD_SELECT_OUT} :
                  sel_rx     ? {8'h00, rx_hold[chan_idx]} :
                  32'h0000_0000;
      end
    end
  end

  // Firmware settings.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      control   <= audio_port_pkg::CONTROL_RESET;
      slave_sel <= audio_port_pkg::SLAVE_SEL_RESET;
    end else if (apb_wr && sel_ctrl) begin
      control <= PWDATA;
    end else if (apb_wr && sel_slave) begin
      slave_sel <= PWDATA[15:0];
    end
  end

  // Shared master clocks.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      half_cnt        <= 8'h00;
      bit_cnt         <= 6'h00;
      BIT_CLOCK_OUT   <= 1'b0;
      WORD_SELECT_OUT <= 1'b0;
      frame_count     <= 16'h0000;
    end else if (!enable) begin
      half_cnt        <= 8'h00;
      BIT_CLOCK_OUT   <= 1'b0;
    end else begin
      half_cnt <= half_tick ? 8'h00 : half_cnt + 8'h01;
      if (half_tick) begin
        BIT_CLOCK_OUT <= !BIT_CLOCK_OUT;
      end
      if (m_fall) begin
        bit_cnt         <= next_bit;
        WORD_SELECT_OUT <= next_ws;
        if (next_bit == 6'h00) begin
          frame_count <= frame_count + 16'h0001;
        end
      end
    end
  end

  // Master clock output
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mclk_acc         <= 11'h000;
      MASTER_CLOCK_OUT <= 1'b0;
    end else if (!enable) begin
      mclk_acc         <= 11'h000;
      MASTER_CLOCK_OUT <= 1'b0;
    end else if (m_fall) begin
      mclk_acc         <= 11'h000;
      MASTER_CLOCK_OUT <= 1'b0;
    end else if (mclk_acc + mclk_step >= mclk_lim) begin
      mclk_acc         <= 11'(mclk_acc + mclk_step - mclk_lim);
      MASTER_CLOCK_OUT <= !MASTER_CLOCK_OUT;
    end else begin
      mclk_acc <= 11'(mclk_acc + mclk_step);
    end
  end

  // Transmit: one line is fetched per cycle, its word lands a cycle later
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      load_idx  <= 3'h0;
      fetch_q   <= 1'b0;
      fetch_idx <= 3'h0;
    end else begin
      load_idx  <= load_idx + 3'h1;
      fetch_q   <= fetch_win;
      fetch_idx <= load_idx;
    end
  end

  generate
    for (g = 0; g < audio_port_pkg::LINES; g++) begin : g_line
      // Slot start: first sample bit (MSB) of a half frame leaves at this fall
      wire        slot_start = m_fall && slot_pos == 5'h00;
      wire [1:0]  src        = slave_sel[2*g+1 -: 2];
      wire        use_ext    = src[1];
      wire        ext_id     = src[0];
      wire        r_rise     = use_ext ? x_rise[ext_id] : m_rise;
      wire        r_ws       = use_ext ? x_ws[ext_id] : WORD_SELECT_OUT;

      // Shift out MSB first, zeros after 24 bits.
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          tx_shift[g]             <= 24'h00_0000;
          AUDIO_DATA_OUT_LINES[g] <= 1'b0;
        end else if (fetch_q && fetch_idx == 3'(g)) begin
          tx_shift[g] <= mem_rd;
        end else if (m_fall) begin
          // Data change on the falling edge only.
          if (slot_pos < 5'(audio_port_pkg::SAMPLE_BITS)) begin
            AUDIO_DATA_OUT_LINES[g] <= tx_shift[g][23];
            tx_shift[g] <= {tx_shift[g][22:0], 1'b0};
          end else begin
            AUDIO_DATA_OUT_LINES[g] <= 1'b0;
          end
          if (slot_start) begin
            AUDIO_DATA_OUT_LINES[g] <= tx_shift[g][23];
          end
        end
      end

      // Receive on the rise of the chosen clock.
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          rx_shift[g]    <= 24'h00_0000;
          rx_bit[g]      <= 6'h00;
          rx_ws_q[g]     <= 1'b0;
          rx_hold[2*g]   <= 24'h00_0000;
          rx_hold[2*g+1] <= 24'h00_0000;
        end else if (r_rise) begin
          rx_ws_q[g] <= r_ws;
          if (r_ws != rx_ws_q[g]) begin
            // New half frame: MSB is one bit later in I2S.
            rx_bit[g] <= fmt_left ? 6'h01 : 6'h00;
            if (rx_bit[g] >= 6'(audio_port_pkg::SAMPLE_BITS)) begin
              if (rx_ws_q[g]) begin
                rx_hold[2*g+1] <= rx_shift[g];
              end else begin
                rx_hold[2*g] <= rx_shift[g];
              end
            end
            if (fmt_left) begin
              rx_shift[g] <= {23'h00_0000, AUDIO_DATA_IN_LINES[g]};
            end
          end else if (rx_bit[g] < 6'(audio_port_pkg::SAMPLE_BITS)) begin
            rx_shift[g] <= {rx_shift[g][22:0], AUDIO_DATA_IN_LINES[g]};
            rx_bit[g]   <= rx_bit[g] + 6'h01;
          end else if (rx_bit[g] < 6'(audio_port_pkg::SLOT_BITS)) begin
            rx_bit[g] <= rx_bit[g] + 6'h01;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/audio_port_pkg.sv
// Constants for the multichannel digital audio port
package audio_port_pkg;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_SLAVE_SEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_TX_BASE   = 8'h40;
  localparam logic [7:0] ADDR_RX_BASE   = 8'h80;
  // Control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORMAT_BIT = 1;
  localparam int CTRL_RATIO_LSB  = 4;
  localparam int CTRL_RATIO_MSB  = 6;
  localparam int CTRL_DIV_LSB    = 8;
  localparam int CTRL_DIV_MSB    = 15;
  // Reset values
  localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
  localparam logic [15:0] SLAVE_SEL_RESET = 16'h0000;
  // Geometry
  localparam int LINES       = 8;
  localparam int SAMPLE_BITS = 24;
  localparam int SLOT_BITS   = 32;
  localparam int FRAME_BITS  = 64;
  localparam int CLOCK_SRCS  = 2;
  // Timing: bit-clock half period in system clocks at minimum divider
  localparam logic [7:0] MIN_HALF_DIV = 8'h01;

  typedef enum logic [2:0] {
    RATIO_128 = 3'h0, RATIO_192 = 3'h1, RATIO_256 = 3'h2,
    RATIO_384 = 3'h3, RATIO_512 = 3'h4, RATIO_768 = 3'h5
  } ratio_type;

  // Master clock half period in bit-clock half periods over 4
  // (mclk = ratio * fs, bclk = 64 fs) -> half mclk = bclk_half * 64/ratio
  typedef enum logic [1:0] {
    FMT_I2S  = 2'b00,
    FMT_LEFT = 2'b01
  } format_type;
endpackage

//--- design/audio_sample_mem.sv
// Sample store: one word per channel, registered read
`timescale 1ns/10ps
`default_nettype none
module audio_sample_mem (
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  // Read port
  input  wire logic [3:0]  rd_addr,
  output var  logic [23:0] rd_data
);
  logic [23:0] mem [0:15];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

//--- design/audio_slave_sync.sv
// Edge detector for one external bit clock / word select pair
`timescale 1ns/10ps
`default_nettype none
module audio_slave_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // External clock pair
  input  wire logic bclk_in,
  input  wire logic ws_in,
  // Recovered events
  output var  logic rise,
  output var  logic fall,
  output var  logic ws
);
  logic bclk_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_q <= 1'b0;
      ws     <= 1'b0;
    end else begin
      bclk_q <= bclk_in;
      // Follows every cycle so a rise sees the current half, not the last
      ws     <= ws_in;
    end
  end

  assign rise = bclk_in && !bclk_q;
  assign fall = !bclk_in && bclk_q;
endmodule
`default_nettype wire
